// *** rtl/sd_fifo_regs.svh ***
// Register offsets, field positions and reset values of the SD host buffer block
`ifndef SD_FIFO_REGS_SVH
`define SD_FIFO_REGS_SVH

`define OFS_DATA_PORT   8'h00
`define OFS_WATERMARK   8'h04
`define OFS_CMD_ARG     8'h08
`define OFS_CMD_XFER    8'h0c
`define OFS_RESP0       8'h10
`define OFS_RESP1       8'h14
`define OFS_RESP2       8'h18
`define OFS_RESP3       8'h1c
`define OFS_PRES_STATE  8'h20
`define OFS_INT_STATUS  8'h24
`define OFS_INT_STAT_EN 8'h28
`define OFS_INT_SIG_EN  8'h2c

`define WM_RD_LSB       0
`define WM_WR_LSB       16
`define WM_RESET        32'h0040_0040

`define XF_INDEX_LSB    0
`define XF_DIR_BIT      8
`define XF_DMA_EN_BIT   9
`define XF_WIDTH_LSB    10
`define XF_MMC_BIT      12

`define PS_BUSY_BIT     0
`define PS_RX_BIT       1
`define PS_EMPTY_BIT    2
`define PS_FULL_BIT     3
`define PS_DMA_BIT      4
`define PS_COUNT_LSB    8

`define EV_CMD_DONE     0
`define EV_XFER_DONE    1
`define EV_CMD_TIMEOUT  2
`define EV_CMD_CRC      3
`define EV_DATA_CRC     4
`define EV_OVERRUN      5
`define EV_UNDERRUN     6
`define EV_WIDTH_ERR    7
`define EV_COUNT        8
`define EN_RESET        8'hff

`endif

// *** rtl/sd_fifo_pkg.sv ***
// Types shared by the SD host buffer block
package sd_fifo_pkg;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_BUSY = 2'b10
  } cmd_state_t;
  typedef enum logic [1:0] {
    WIDTH_1 = 2'b00,
    WIDTH_4 = 2'b01,
    WIDTH_8 = 2'b10
  } bus_width_t;
endpackage

// *** rtl/sd_word_fifo.sv ***
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sd_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 128
) (
  input  wire logic                     clk,       // Clock
  input  wire logic                     arst_n,    // Async reset, low
  input  wire logic                     flush,     // Empty the buffer
  input  wire logic                     in_valid,  // Word offered
  output logic                          in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0]         in_data,   // Word in
  output logic                          out_valid, // Word held
  input  wire logic                     out_ready, // Word taken
  output logic [WIDTH-1:0]              out_data,  // Oldest word
  output logic [$clog2(DEPTH):0]        count      // Words held
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sd_word_fifo: DEPTH must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Neither side may hand over a word while a flush discards it
  assign in_ready  = (count_reg != DEPTH[AW:0]) & ~flush;
  assign out_valid = (count_reg != '0) & ~flush;
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;
  assign out_data  = mem[rptr_reg];
  assign count     = count_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/sd_host_fifo_dma.sv ***
// SD host data buffer, DMA request, command and status logic on AHB-Lite
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sd_fifo_regs.svh"

// Function
// - One buffer of 128 words of 32 bits holds data in either direction.
// - The data port moves one word per access: a read pops, a write pushes; here reads pop only when receiving and writes push only when sending.
// - When receiving, request DMA while held words exceed the read watermark.
// - When sending, request DMA while free space exceeds the write watermark.
// - Four 32-bit response registers hold the card's answer for direct reading.
// - Writing argument then transfer type issues the command to the card.
// - Read-only present state and status show activity, fill, errors and events.
// - A defined event sets its status bit and may raise the interrupt.
// - Per-event enables decide recording in status and driving the interrupt.
// - Bus widths 1, 4 or 8 bits for MMC, and 1 or 4 bits for SD and SDIO.
// - Only the SD bus protocol is spoken; SPI mode does not exist.
// - Command timeouts and CRC errors are detected and flagged as errors.
module sd_host_fifo_dma
  import sd_fifo_pkg::*;
#(
  parameter int DEPTH = 128
) (
  input  wire logic         CLK,          // Clock, 25 MHz
  input  wire logic         ARST_N,       // Async reset, low
  input  wire logic         HSEL,         // Slave select
  input  wire logic [7:0]   HADDR,        // Byte address
  input  wire logic [1:0]   HTRANS,       // Transfer type
  input  wire logic         HWRITE,       // Write access
  input  wire logic [2:0]   HSIZE,        // Word only
  input  wire logic [31:0]  HWDATA,       // Write data
  input  wire logic         HREADY,       // Bus ready
  output logic [31:0]       HRDATA,       // Read data
  output logic              HREADYOUT,    // Never stalls
  output logic              HRESP,        // Always OKAY
  output logic              DMA_REQ,      // Buffer wants service
  output logic              IRQ,          // Gated interrupt
  output logic              CMD_START,    // Issue pulse
  output logic [5:0]        CMD_INDEX,    // Command index
  output logic [31:0]       CMD_ARG,      // Command argument
  output logic [1:0]        BUS_WIDTH,    // 0:1 1:4 2:8 bits
  output logic              CARD_TO_HOST, // Transfer direction
  input  wire logic         RESP_VALID,   // Response arrived
  input  wire logic [127:0] RESP_DATA,    // Response words
  input  wire logic         RESP_TIMEOUT, // No response
  input  wire logic         RESP_CRC_ERR, // Response CRC bad
  input  wire logic         DATA_CRC_ERR, // Data CRC bad
  input  wire logic         XFER_DONE,    // Data block done
  input  wire logic         RX_VALID,     // Card word offered
  input  wire logic [31:0]  RX_DATA,      // Card word
  output logic              RX_READY,     // Buffer takes it
  output logic              TX_VALID,     // Word for card
  output logic [31:0]       TX_DATA,      // Word for card
  input  wire logic         TX_READY      // Card takes it
);
  localparam int CW = $clog2(DEPTH) + 1;

  initial begin
    if (DEPTH > 255 || DEPTH < 2) begin
      $error("sd_host_fifo_dma: DEPTH must fit the 8-bit watermark fields");
    end
  end

  logic [31:0]          wm_reg;
  logic [31:0]          arg_reg;
  logic [12:0]          xfer_reg;
  logic [31:0]          resp_reg [4];
  logic [`EV_COUNT-1:0] stat_reg;
  logic [`EV_COUNT-1:0] stat_en_reg;
  logic [`EV_COUNT-1:0] sig_en_reg;
  logic [`EV_COUNT-1:0] events;
  cmd_state_t           cmd_state_reg;
  logic                 start_reg;
  logic                 irq_reg;
  logic [31:0]          rdata_reg;
  logic                 wr_pend_reg;
  logic [7:0]           wr_addr_reg;
  logic                 acc;
  logic                 bus_rd;
  logic                 bus_push;
  logic                 bus_pop;
  logic                 underrun;
  logic                 width_ok;
  logic                 xfer_wr;
  logic                 rx_dir;
  logic [7:0]           read_watermark_level;
  logic [7:0]           write_watermark_level;
  logic [CW-1:0]        fill;
  logic [CW-1:0]        space;
  logic                 f_in_valid;
  logic                 f_in_ready;
  logic [31:0]          f_in_data;
  logic                 f_out_valid;
  logic                 f_out_ready;
  logic [31:0]          f_out_data;
  logic [31:0]          rd_mux;

  // Legal width for the card kind
  function automatic logic width_legal(input logic [1:0] w, input logic mmc);
    width_legal = (w == WIDTH_1) || (w == WIDTH_4) || (w == WIDTH_8 && mmc);
  endfunction

  assign acc       = HSEL & HTRANS[1] & HREADY;
  assign bus_rd    = acc & ~HWRITE;
  assign rx_dir    = xfer_reg[`XF_DIR_BIT];
  assign read_watermark_level    = wm_reg[`WM_RD_LSB +: 8];
  assign write_watermark_level    = wm_reg[`WM_WR_LSB +: 8];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;

  // Address phase: writes are applied in the data phase when HWDATA is valid
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc & HWRITE;
      wr_addr_reg <= HADDR;
    end
  end

  // Data port steering: one buffer, its ends swap with the direction
  assign bus_push    = wr_pend_reg & (wr_addr_reg == `OFS_DATA_PORT) & ~rx_dir;
  assign bus_pop     = bus_rd & (HADDR == `OFS_DATA_PORT) & rx_dir;
  assign underrun    = bus_pop & ~f_out_valid;
  assign f_in_valid  = rx_dir ? RX_VALID : bus_push;
  assign f_in_data   = rx_dir ? RX_DATA : HWDATA;
  assign f_out_ready = rx_dir ? bus_pop : TX_READY;
  assign RX_READY    = rx_dir & f_in_ready;
  assign TX_VALID    = ~rx_dir & f_out_valid;
  assign TX_DATA     = f_out_data;
  assign xfer_wr     = wr_pend_reg & (wr_addr_reg == `OFS_CMD_XFER);

  // Switching direction or issuing a command flushes stale words
  sd_word_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .flush     (xfer_wr && width_ok && cmd_state_reg == CMD_IDLE),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .count     (fill)
  );

  assign space = CW'(DEPTH) - fill;

  // Combinational so the request falls in the same cycle the level moves
  always_comb begin
    if (!xfer_reg[`XF_DMA_EN_BIT]) begin
      DMA_REQ = 1'b0;
    end else if (rx_dir) begin
      // Wide compare: a watermark above the depth must not wrap
      DMA_REQ = (fill > 32'(read_watermark_level));
    end else begin
      DMA_REQ = (space > 32'(write_watermark_level));
    end
  end

  assign width_ok = width_legal(HWDATA[`XF_WIDTH_LSB +: 2], HWDATA[`XF_MMC_BIT]);

  // Configuration registers; SPI mode has no control bit at all
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wm_reg      <= `WM_RESET;
      arg_reg     <= 32'h0000_0000;
      xfer_reg    <= 13'h0000;
      stat_en_reg <= `EN_RESET;
      sig_en_reg  <= 8'h00;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        `OFS_WATERMARK: begin
          wm_reg <= HWDATA & 32'h00ff_00ff;
        end
        `OFS_CMD_ARG: begin
          arg_reg <= HWDATA;
        end
        `OFS_CMD_XFER: begin
          if (cmd_state_reg == CMD_IDLE && width_ok) begin
            xfer_reg <= HWDATA[12:0];
          end
        end
        `OFS_INT_STAT_EN: begin
          stat_en_reg <= HWDATA[`EV_COUNT-1:0];
        end
        `OFS_INT_SIG_EN: begin
          sig_en_reg <= HWDATA[`EV_COUNT-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Command sequencing: one command in flight, refused while busy
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_state_reg <= CMD_IDLE;
      start_reg     <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      case (cmd_state_reg)
        CMD_IDLE: begin
          if (xfer_wr && width_ok) begin
            cmd_state_reg <= CMD_BUSY;
            start_reg     <= 1'b1;
          end
        end
        CMD_BUSY: begin
          if (RESP_VALID || RESP_TIMEOUT) begin
            cmd_state_reg <= CMD_IDLE;
          end
        end
        default: begin
          cmd_state_reg <= CMD_IDLE;
        end
      endcase
    end
  end

  assign CMD_START    = start_reg;
  assign CMD_INDEX    = xfer_reg[`XF_INDEX_LSB +: 6];
  assign CMD_ARG      = arg_reg;
  assign BUS_WIDTH    = xfer_reg[`XF_WIDTH_LSB +: 2];
  assign CARD_TO_HOST = rx_dir;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 4; i++) begin
        resp_reg[i] <= 32'h0000_0000;
      end
    end else if (RESP_VALID && cmd_state_reg == CMD_BUSY) begin
      for (int i = 0; i < 4; i++) begin
        resp_reg[i] <= RESP_DATA[32*i +: 32];
      end
    end
  end

  // Event sources
  always_comb begin
    events                  = '0;
    events[`EV_CMD_DONE]    = RESP_VALID & (cmd_state_reg == CMD_BUSY);
    events[`EV_XFER_DONE]   = XFER_DONE;
    events[`EV_CMD_TIMEOUT] = RESP_TIMEOUT;
    events[`EV_CMD_CRC]     = RESP_CRC_ERR;
    events[`EV_DATA_CRC]    = DATA_CRC_ERR;
    events[`EV_OVERRUN]     = bus_push & ~f_in_ready;
    events[`EV_UNDERRUN]    = underrun;
    events[`EV_WIDTH_ERR]   = xfer_wr & ~width_ok;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_reg <= '0;
    end else begin
      if (wr_pend_reg && wr_addr_reg == `OFS_INT_STATUS) begin
        stat_reg <= (stat_reg & ~HWDATA[`EV_COUNT-1:0]) | (events & stat_en_reg);
      end else begin
        stat_reg <= stat_reg | (events & stat_en_reg);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & sig_en_reg);
    end
  end

  assign IRQ = irq_reg;

  // Read mux; present state is read only, interrupt status is write one to clear
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (HADDR)
      `OFS_DATA_PORT:   rd_mux = (rx_dir && f_out_valid) ? f_out_data : 32'h0000_0000;
      `OFS_WATERMARK:   rd_mux = wm_reg;
      `OFS_CMD_ARG:     rd_mux = arg_reg;
      `OFS_CMD_XFER:    rd_mux = {19'h00000, xfer_reg};
      `OFS_RESP0:       rd_mux = resp_reg[0];
      `OFS_RESP1:       rd_mux = resp_reg[1];
      `OFS_RESP2:       rd_mux = resp_reg[2];
      `OFS_RESP3:       rd_mux = resp_reg[3];
      `OFS_PRES_STATE: begin
        rd_mux[`PS_BUSY_BIT]           = (cmd_state_reg == CMD_BUSY);
        rd_mux[`PS_RX_BIT]             = rx_dir;
        rd_mux[`PS_EMPTY_BIT]          = ~f_out_valid;
        rd_mux[`PS_FULL_BIT]           = ~f_in_ready;
        rd_mux[`PS_DMA_BIT]            = DMA_REQ;
        rd_mux[`PS_COUNT_LSB +: 8]     = 8'(fill);
      end
      `OFS_INT_STATUS:  rd_mux = {24'h000000, stat_reg};
      `OFS_INT_STAT_EN: rd_mux = {24'h000000, stat_en_reg};
      `OFS_INT_SIG_EN:  rd_mux = {24'h000000, sig_en_reg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_rx_dma_level: assert property (
    (xfer_reg[`XF_DMA_EN_BIT] && rx_dir && fill > 32'(read_watermark_level)) |-> DMA_REQ)
    else $error("receive DMA request missing above watermark");
  chk_tx_dma_level: assert property (
    (xfer_reg[`XF_DMA_EN_BIT] && !rx_dir && space > 32'(write_watermark_level)) |-> DMA_REQ)
    else $error("transmit DMA request missing above watermark");
  chk_dma_withdraw: assert property (
    (DMA_REQ && rx_dir && bus_pop && !f_in_valid && fill == 32'(read_watermark_level) + 32'd1) |=> !DMA_REQ)
    else $error("receive DMA request held without data");
  chk_cmd_issue: assert property (
    (xfer_wr && cmd_state_reg == CMD_IDLE && width_ok) |=> CMD_START ##1 !CMD_START)
    else $error("command not issued as a single pulse");
  chk_resp_capture: assert property (
    (RESP_VALID && cmd_state_reg == CMD_BUSY) |=> resp_reg[3] == $past(RESP_DATA[127:96]))
    else $error("response word not captured");
  chk_timeout_flag: assert property (
    (RESP_TIMEOUT && stat_en_reg[`EV_CMD_TIMEOUT]) |=> stat_reg[`EV_CMD_TIMEOUT])
    else $error("command timeout not flagged");
  chk_status_gate: assert property (
    (!stat_reg[`EV_DATA_CRC] && !stat_en_reg[`EV_DATA_CRC]) |=> !stat_reg[`EV_DATA_CRC])
    else $error("disabled event recorded");
  chk_irq_follow: assert property (
    (|(stat_reg & sig_en_reg)) |=> IRQ)
    else $error("interrupt not raised for enabled event");
  chk_width_legal: assert property (
    !(BUS_WIDTH == WIDTH_8 && !xfer_reg[`XF_MMC_BIT]) && BUS_WIDTH != 2'b11)
    else $error("illegal bus width in use");
  chk_pop_word: assert property (
    (bus_pop && f_out_valid) |=> fill == $past(fill) - CW'(1) + CW'($past(f_in_valid && f_in_ready)))
    else $error("data port read did not pop one word");

  cov_rx_dma: cover property (rx_dir && DMA_REQ ##[1:50] !DMA_REQ);
  cov_tx_dma: cover property (!rx_dir && DMA_REQ ##[1:50] !DMA_REQ);
  cov_cmd_rsp: cover property (CMD_START ##[1:100] RESP_VALID);
  cov_full: cover property (!f_in_ready);
endmodule
`default_nettype wire

// *** tb/sd_card_model.sv ***
// Behavioural card model: answers commands and streams words to and from the buffer
`timescale 1ns/10ps
`default_nettype none
module sd_card_model (
  input  wire logic         clk,          // Clock
  input  wire logic         arst_n,       // Async reset, low
  input  wire logic         cmd_start,    // Command issued
  input  wire logic [5:0]   cmd_index,    // Command index
  input  wire logic [31:0]  cmd_arg,      // Command argument
  input  wire logic [1:0]   resp_mode,    // 0 good, 1 silent, 2 bad CRC
  input  wire logic [7:0]   rx_limit,     // Words to send
  input  wire logic         tx_en,        // Accept words
  input  wire logic [1:0]   ev,           // Done and data CRC pulses
  input  wire logic         rx_ready,     // Buffer takes word
  input  wire logic         tx_valid,     // Word for card
  input  wire logic [31:0]  tx_data,      // Word for card
  output logic              resp_valid,   // Response present
  output logic [127:0]      resp_data,    // Response words
  output logic              resp_timeout, // No response
  output logic              resp_crc_err, // Response CRC bad
  output logic              data_crc_err, // Data CRC bad
  output logic              xfer_done,    // Block done
  output logic              rx_valid,     // Word offered
  output logic [31:0]       rx_data,      // Word offered
  output logic              tx_ready      // Word taken
);
  integer      seed = 60;
  integer      wait_cnt;
  logic [7:0]  rx_sent;
  logic [7:0]  rx_next;
  logic [31:0] tx_got[$];
  assign rx_next = rx_sent + {7'h0, rx_valid & rx_ready};
  // Random delay so that prompt and slow answers both occur
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= -1;
      resp_valid <= 1'b0;
      resp_timeout <= 1'b0;
      resp_crc_err <= 1'b0;
      resp_data <= '0;
    end else begin
      resp_valid <= 1'b0;
      resp_timeout <= 1'b0;
      resp_crc_err <= 1'b0;
      // Stale response lines toggle so a late sample cannot match
      resp_data <= ~resp_data;
      if (cmd_start) begin
        wait_cnt <= $unsigned($random(seed)) % 12;
      end else if (wait_cnt == 0) begin
        resp_valid <= resp_mode != 2'd1;
        resp_timeout <= resp_mode == 2'd1;
        resp_crc_err <= resp_mode == 2'd2;
        resp_data <= {cmd_arg ^ 32'h0f0f_0f0f, 26'h0, cmd_index, ~cmd_arg, cmd_arg};
        wait_cnt <= -1;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
  // A word once offered is held until the buffer takes it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sent <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_sent <= rx_next;
      if (rx_valid && !rx_ready) begin
        rx_valid <= 1'b1;
      end else if (rx_next < rx_limit) begin
        rx_valid <= 1'b1;
        rx_data <= 32'hc0de_0000 + {24'h0, rx_next};
      end else begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
      xfer_done <= 1'b0;
      data_crc_err <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) tx_got.push_back(tx_data);
      tx_ready <= tx_en && ($random(seed) & 1);
      xfer_done <= ev[0];
      data_crc_err <= ev[1];
    end
  end
endmodule
`default_nettype wire

// *** tb/sd_host_fifo_dma_request_bench.sv ***
// Self-checking bench for the SD host buffer, command and status block
`timescale 1ns/10ps
`default_nettype none
`include "sd_fifo_regs.svh"
module sd_host_fifo_dma_request_bench
  import sd_fifo_pkg::*;
;
  localparam int DEPTH = 32;
  localparam int RD_WM = 4;
  localparam int WR_WM = 8;
  logic         clk, arst_n, hsel, hwrite, hreadyout, hresp, dma_req, irq, cmd_start;
  logic         card_to_host, resp_valid, resp_timeout, resp_crc_err, data_crc_err;
  logic         xfer_done, rx_valid, rx_ready, tx_valid, tx_ready, tx_en;
  logic [1:0]   htrans, bus_width, resp_mode, ev;
  logic [5:0]   cmd_index;
  logic [7:0]   haddr, rx_limit;
  logic [31:0]  hwdata, hrdata, cmd_arg, rx_data, tx_data, rdata;
  logic [127:0] resp_data;
  integer       seed = 60;
  int           fail_count = 0;
  int           checks_done = 0;
  int           k;

  sd_host_fifo_dma #(.DEPTH(DEPTH)) uut (
    .CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .DMA_REQ(dma_req), .IRQ(irq),
    .CMD_START(cmd_start), .CMD_INDEX(cmd_index), .CMD_ARG(cmd_arg), .BUS_WIDTH(bus_width),
    .CARD_TO_HOST(card_to_host), .RESP_VALID(resp_valid), .RESP_DATA(resp_data),
    .RESP_TIMEOUT(resp_timeout), .RESP_CRC_ERR(resp_crc_err), .DATA_CRC_ERR(data_crc_err),
    .XFER_DONE(xfer_done), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready));

  sd_card_model card (
    .clk(clk), .arst_n(arst_n), .cmd_start(cmd_start), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg), .resp_mode(resp_mode), .rx_limit(rx_limit), .tx_en(tx_en), .ev(ev),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_timeout(resp_timeout), .resp_crc_err(resp_crc_err),
    .data_crc_err(data_crc_err), .xfer_done(xfer_done), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready));

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Address phase held until ready, then data phase held until ready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, rdata);
  endtask
  task automatic rd_cmp(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp_word(what, exp, rdata);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (rdata[b] !== v && n < 200);
    cmp_bit("poll", v, rdata[b]);
  endtask
  task automatic pulse(input logic [1:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 2'b00;
  endtask
  // Event bit to wait on: done, timeout, CRC, or width error when refused
  task automatic issue(input logic [31:0] xf, input logic [1:0] mode, input logic ok);
    logic [31:0]  arg;
    logic [127:0] resp;
    int           eb;
    arg = $random(seed);
    resp = {arg ^ 32'h0f0f_0f0f, 26'h0, xf[5:0], ~arg, arg};
    eb = ok ? (mode == 2'd0 ? 0 : mode + 1) : 7;
    resp_mode <= mode;
    wr(`OFS_CMD_ARG, arg);
    wr(`OFS_CMD_XFER, xf);
    @(negedge clk);
    cmp_bit("cmd_start", ok, cmd_start);
    if (ok) begin
      cmp_word("cmd_arg", arg, cmd_arg);
      cmp_word("cmd_setup", {23'h0, xf[11:10], xf[8], xf[5:0]},
               {23'h0, bus_width, card_to_host, cmd_index});
      @(negedge clk);
      cmp_bit("cmd_pulse", 1'b0, cmd_start);
    end
    poll(`OFS_INT_STATUS, eb, 1'b1);
    cmp_bit("event_flag", 1'b1, rdata[eb]);
    cmp_bit("irq_mask", ok && mode == 2'd1, irq);
    if (ok && mode == 2'd0)
      for (eb = 0; eb < 4; eb++) begin
        rd(`OFS_RESP0 + 8'(4 * eb));
        cmp_word("resp_word", resp[32*eb +: 32], rdata);
      end
    wr(`OFS_INT_STATUS, 32'h0000_00ff);
    @(negedge clk);
    @(negedge clk);
    cmp_bit("irq_clear", 1'b0, irq);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs under a thousand cycles; this allows twenty thousand
  initial begin
    #800000;
    fail_count++;
    $display("Watchdog expired");
    tally_and_finish();
  end

  initial begin
    {arst_n, hsel, hwrite, htrans, haddr, hwdata, tx_en, rx_limit, ev, resp_mode} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd_cmp("watermark", `OFS_WATERMARK, `WM_RESET);
    rd_cmp("stat_en", `OFS_INT_STAT_EN, {24'h0, `EN_RESET});
    rd_cmp("sig_en", `OFS_INT_SIG_EN, 32'h0);
    rd_cmp("pres_reset", `OFS_PRES_STATE, 32'h0000_0004);
    wr(`OFS_PRES_STATE, 32'hffff_ffff);
    rd_cmp("pres_ro", `OFS_PRES_STATE, 32'h0000_0004);
    wr(8'h30, 32'h1234_5678);
    rd_cmp("unmapped", 8'h30, 32'h0);
    cmp_bit("hresp", 1'b0, hresp);
    cmp_bit("hreadyout", 1'b1, hreadyout);
    $display("Test registers done");
    wr(`OFS_INT_SIG_EN, 32'h0000_0004);
    for (k = 0; k < 8; k++)
      issue({19'h0, k[2], k[1:0], 2'b01, 2'b00, 6'($random(seed))}, 2'(k % 3),
            k[1:0] < 2'd2 || k == 6);
    $display("Test commands done");
    wr(`OFS_WATERMARK, {8'h0, 8'(WR_WM), 8'h0, 8'(RD_WM)});
    issue(32'h0000_0703, 2'd0, 1'b1);
    rx_limit <= 8'(DEPTH);
    poll(`OFS_PRES_STATE, `PS_FULL_BIT, 1'b1);
    cmp_word("pres_full", {16'h0, 8'(DEPTH), 8'h1a}, rdata);
    cmp_bit("rx_ready_full", 1'b0, rx_ready);
    for (k = 0; k <= DEPTH; k++) begin
      @(negedge clk);
      cmp_bit("rx_dma_req", DEPTH - k > RD_WM, dma_req);
      rd(`OFS_DATA_PORT);
      cmp_word("rx_word", k < DEPTH ? 32'hc0de_0000 + k : 32'h0, rdata);
    end
    rd(`OFS_INT_STATUS);
    cmp_bit("underrun", 1'b1, rdata[`EV_UNDERRUN]);
    $display("Test receive done");
    issue(32'h0000_0605, 2'd0, 1'b1);
    for (k = 0; k <= DEPTH; k++) begin
      @(negedge clk);
      cmp_bit("tx_dma_req", DEPTH - k > WR_WM, dma_req);
      wr(`OFS_DATA_PORT, 32'h7a00_0000 + k);
    end
    rd(`OFS_INT_STATUS);
    cmp_bit("overrun", 1'b1, rdata[`EV_OVERRUN]);
    rd_cmp("pres_tx_full", `OFS_PRES_STATE, {16'h0, 8'(DEPTH), 8'h08});
    tx_en <= 1'b1;
    poll(`OFS_PRES_STATE, `PS_EMPTY_BIT, 1'b1);
    cmp_word("tx_count", DEPTH, 32'(card.tx_got.size()));
    for (k = 0; k < DEPTH && k < card.tx_got.size(); k++)
      cmp_word("tx_word", 32'h7a00_0000 + k, card.tx_got[k]);
    $display("Test transmit done");
    wr(`OFS_INT_STATUS, 32'h0000_00ff);
    wr(`OFS_INT_STAT_EN, 32'h0000_00ed);
    pulse(2'b11);
    rd_cmp("masked_status", `OFS_INT_STATUS, 32'h0);
    wr(`OFS_INT_STAT_EN, 32'h0000_00ff);
    wr(`OFS_INT_SIG_EN, 32'h0000_0002);
    pulse(2'b11);
    rd_cmp("event_status", `OFS_INT_STATUS, 32'h0000_0012);
    cmp_bit("irq_event", 1'b1, irq);
    $display("Test events done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
